//--- memb_ctrl.sv
// Behaviour
// - disable bit set and idle: pins are ports
// - all-external mode: bus always owns pins
// - all-internal mode: ports only, control writes ignored
// - external access takes pins despite disable bit
// - disable deferred until running from internal memory
// - idle bus: lines tristate, strobes high, ale low
// - table cycles stretched by wait code
// - word style: pair writes, high strobe on second
// - byte-select style: byte doubled, high strobe, byte select
// - byte style: byte doubled, high or low strobe
// - sixteen-bit data path only
// - ale high while low address is out
// - output strobe reads both bytes together
// - chip select low per access, high asleep
// - ad line n carries byte address bit n+1 then data bit n
// - bus control port bit order fixed
// - byte style strobe chosen by pointer lsb
// - word style even write: latch only, no strobe
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
`include "memb_defs.svh"
module memb_ctrl (
   input  wire logic                 sys_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  memb_pkg::memb_pm_e        pm_mode,
   input  wire logic                 core_exec_ext,
   input  wire logic                 core_sleep,
   input  wire logic                 core_req,
   input  memb_pkg::memb_kind_e      core_kind,
   input  wire logic [20:0]          core_addr,
   input  wire logic [7:0]           core_table_latch,
   output logic                      core_done,
   output logic      [15:0]          core_rdata,
   input  wire logic [7:0]           low_bus_port_dout,
   input  wire logic [7:0]           low_bus_port_oe_n,
   input  wire logic [7:0]           high_bus_port_dout,
   input  wire logic [7:0]           high_bus_port_oe_n,
   input  wire logic [3:0]           upper_address_port_dout,
   input  wire logic [3:0]           upper_address_port_oe_n,
   input  wire logic [7:0]           bus_control_port_dout,
   input  wire logic [7:0]           bus_control_port_oe_n,
   output logic      [7:0]           low_bus_port_din,
   output logic      [7:0]           high_bus_port_din,
   output logic      [3:0]           upper_address_port_din,
   output logic      [7:0]           bus_control_port_din,
   input  wire logic [15:0]          ad_in,
   output logic      [15:0]          ad_out,
   output logic      [15:0]          ad_oe_n,
   input  wire logic [3:0]           upper_addr_in,
   output logic      [3:0]           upper_addr_out,
   output logic      [3:0]           upper_addr_oe_n,
   input  wire logic [7:0]           bus_ctrl_in,
   output logic      [7:0]           bus_ctrl_out,
   output logic      [7:0]           bus_ctrl_oe_n
);
   ////////////////////////////////////////////////////////////////////////
   // data phase length: one instruction cycle plus table waits
   function automatic logic [7:0] data_clks(memb_pkg::memb_kind_e k,
                                            logic [1:0] code);
      logic [7:0] n;
      n = 8'h01;
      if (k != memb_pkg::K_FETCH)
         n = 8'h01 + {6'h00, `MEMB_WAIT_MAX - code};
      data_clks = 8'(n * `MEMB_TCY_CLKS);
   endfunction

   memb_pkg::memb_state_e state_r;       // bus cycle state
   memb_pkg::memb_kind_e  kind_r;        // kind of the cycle in flight
   logic [7:0]            ctrl_r;        // external_bus_control
   logic                  external_bus_disable_app_r;   // disable bit as applied
   logic [20:0]           addr_r;        // captured byte address
   logic [7:0]            tl_r;          // captured table latch byte
   logic [7:0]            hold_r;        // word style low byte latch
   logic [1:0]            wm_r;          // write style of this cycle
   logic [7:0]            dlen_r;        // data phase length of cycle
   logic                  wb_ack_r;      // bus acknowledge
   logic [31:0]           wb_dat_r;      // bus read data
   logic                  done_r;        // request finished pulse
   logic [15:0]           rdata_r;       // read word
   logic [15:0]           ad_nxt, ad_oe_nxt, ad_r, ad_oe_r;
   logic [3:0]            up_nxt, up_oe_nxt, up_r, up_oe_r;
   logic [7:0]            ct_nxt, ct_oe_nxt, ct_r, ct_oe_r;
   logic [27:0]           pins_sync;     // synchronised pin levels
   logic                  busy;          // a bus cycle is running
   logic                  owned;         // bus function holds the pins
   logic                  take;          // accept core request now
   logic                  ph_load;       // start a new phase
   logic [7:0]            ph_val;        // length-1 of next phase
   logic                  ph_done;       // current phase over
   logic                  wb_hit;        // new wishbone access
   logic                  is_wr;         // cycle is a table write

   ////////////////////////////////////////////////////////////////////////
   // pin inputs pass two flops before anything reads them
   memb_sync #(.W(28)) u_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in ({bus_ctrl_in, upper_addr_in, ad_in}),
      .sync_out (pins_sync)
   );
   assign low_bus_port_din       = pins_sync[7:0];
   assign high_bus_port_din      = pins_sync[15:8];
   assign upper_address_port_din = pins_sync[19:16];
   assign bus_control_port_din   = pins_sync[27:20];

   // one shared timer paces every phase of the cycle
   memb_phase_timer u_timer (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .load     (ph_load),
      .load_val (ph_val),
      .expired  (ph_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave: one wait, then ack for one cycle
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_r;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         wb_ack_r <= 1'b0;
      else
         wb_ack_r <= wb_hit;
   end

   // read mux, unmapped offsets read zero
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         wb_dat_r <= 32'h0000_0000;
      else if (wb_hit)
      begin
         case (wb_adr_i)
            `MEMB_ADR_CTRL:
               wb_dat_r <= {24'h00_0000, ctrl_r};
            `MEMB_ADR_STAT:
               wb_dat_r <= {29'h0000_0000, external_bus_disable_app_r, busy, owned};
            default:
               wb_dat_r <= 32'h0000_0000;
         endcase
      end
   end

   // control register; reserved bits never store
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         ctrl_r <= `MEMB_CTRL_RST;
      else if (wb_hit && wb_we_i && wb_sel_i[0] &&
               wb_adr_i == `MEMB_ADR_CTRL &&
               pm_mode != memb_pkg::PM_MC)
         ctrl_r <= wb_dat_i[7:0] & `MEMB_CTRL_WMASK;
   end

   // setting the disable bit waits while code runs externally;
   // clearing it acts at once so the bus is never lost
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         external_bus_disable_app_r <= 1'b0;
      else if (!ctrl_r[`MEMB_EXTERNAL_BUS_DISABLE_BIT])
         external_bus_disable_app_r <= 1'b0;
      else if (!core_exec_ext)
         external_bus_disable_app_r <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // pin ownership
   assign busy = (state_r != memb_pkg::S_IDLE);
   assign is_wr = (kind_r == memb_pkg::K_TABLE_WRITE_OP);

   always_comb
   begin
      case (pm_mode)
         memb_pkg::PM_MP: owned = 1'b1;
         memb_pkg::PM_MC: owned = 1'b0;
         default:         owned = busy || core_req ||
                                  !external_bus_disable_app_r;
      endcase
   end

   // requests wait while asleep and in the cycle the done pulse is high
   assign take = (state_r == memb_pkg::S_IDLE) && core_req &&
                 !core_sleep && !done_r;

   ////////////////////////////////////////////////////////////////////////
   // bus cycle sequencer
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         state_r <= memb_pkg::S_IDLE;
      else
      begin
         case (state_r)
            memb_pkg::S_IDLE:
               if (take && pm_mode == memb_pkg::PM_MC)
                  state_r <= memb_pkg::S_FINISH;      // no bus to use
               else if (take)
                  state_r <= memb_pkg::S_ADDR;
            memb_pkg::S_ADDR:
               if (ph_done)
                  state_r <= memb_pkg::S_LATCH;
            memb_pkg::S_LATCH:
               if (ph_done)
                  state_r <= memb_pkg::S_DATA;
            memb_pkg::S_DATA:
               if (ph_done)
                  state_r <= memb_pkg::S_FINISH;
            memb_pkg::S_FINISH:
               if (ph_done)
                  state_r <= memb_pkg::S_IDLE;
            default:
               state_r <= memb_pkg::S_IDLE;
         endcase
      end
   end

   // phase loads on every move of the sequencer except the return to idle
   always_comb
   begin
      ph_load = 1'b0;
      ph_val  = 8'h00;
      case (state_r)
         memb_pkg::S_IDLE:
         begin
            ph_load = take;
            ph_val  = (pm_mode == memb_pkg::PM_MC) ?
                      `MEMB_FINISH_CLKS - 8'h01 : `MEMB_ADDR_CLKS - 8'h01;
         end
         memb_pkg::S_ADDR:
         begin
            ph_load = ph_done;
            ph_val  = `MEMB_LATCH_CLKS - 8'h01;
         end
         memb_pkg::S_LATCH:
         begin
            ph_load = ph_done;
            ph_val  = dlen_r - 8'h01;
         end
         memb_pkg::S_DATA:
         begin
            ph_load = ph_done;
            ph_val  = `MEMB_FINISH_CLKS - 8'h01;
         end
         default:
         begin
            ph_load = 1'b0;
            ph_val  = 8'h00;
         end
      endcase
   end

   // request capture; the word latch takes even-address bytes
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         kind_r <= memb_pkg::K_FETCH;
         addr_r <= 21'h00_0000;
         tl_r   <= 8'h00;
         wm_r   <= 2'h0;
         dlen_r <= `MEMB_TCY_CLKS;
         hold_r <= 8'h00;
      end
      else if (take)
      begin
         kind_r <= core_kind;
         addr_r <= core_addr;
         tl_r   <= core_table_latch;
         wm_r   <= ctrl_r[`MEMB_WM_HI:`MEMB_WM_LO];
         dlen_r <= data_clks(core_kind,
                             ctrl_r[`MEMB_WAIT_HI:`MEMB_WAIT_LO]);
         if (core_kind == memb_pkg::K_TABLE_WRITE_OP &&
             ctrl_r[`MEMB_WM_HI] && !core_addr[0])
            hold_r <= core_table_latch;
      end
   end

   // read word sampled at the end of the data phase
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         rdata_r <= 16'h0000;
      else if (state_r == memb_pkg::S_DATA && ph_done && !is_wr)
         rdata_r <= pins_sync[15:0];
   end

   // done pulse as the cycle returns to idle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         done_r <= 1'b0;
      else
         done_r <= (state_r == memb_pkg::S_FINISH) && ph_done;
   end

   ////////////////////////////////////////////////////////////////////////
   // next pin levels; control pins idle as ale and ba0 low, rest high
   always_comb
   begin
      ad_nxt    = 16'h0000;
      ad_oe_nxt = 16'hFFFF;
      up_nxt    = 4'h0;
      up_oe_nxt = 4'hF;
      ct_nxt    = `MEMB_CTRL_IDLE;
      ct_oe_nxt = 8'h00;
      if (!owned)
      begin
         ad_nxt    = {high_bus_port_dout, low_bus_port_dout};
         ad_oe_nxt = {high_bus_port_oe_n, low_bus_port_oe_n};
         up_nxt    = upper_address_port_dout;
         up_oe_nxt = upper_address_port_oe_n;
         ct_nxt    = bus_control_port_dout;
         ct_oe_nxt = bus_control_port_oe_n;
      end
      else if (busy)
      begin
         up_nxt    = addr_r[20:17];
         up_oe_nxt = 4'h0;
         ct_nxt[`MEMB_PIN_CE]  = 1'b0;
         ct_nxt[`MEMB_PIN_BA0] = addr_r[0];
         case (state_r)
            memb_pkg::S_ADDR, memb_pkg::S_LATCH:
            begin
               ad_nxt    = addr_r[16:1];
               ad_oe_nxt = 16'h0000;
               ct_nxt[`MEMB_PIN_ALE] =
                  (state_r == memb_pkg::S_ADDR);
            end
            memb_pkg::S_DATA, memb_pkg::S_FINISH:
            begin
               if (!is_wr)
               begin
                  ct_nxt[`MEMB_PIN_UB] = 1'b0;
                  ct_nxt[`MEMB_PIN_LB] = 1'b0;
                  ct_nxt[`MEMB_PIN_OE] =
                     (state_r != memb_pkg::S_DATA);
               end
               else if (wm_r[1])
               begin
                  if (addr_r[0])
                  begin
                     ad_nxt    = {tl_r, hold_r};
                     ad_oe_nxt = 16'h0000;
                     ct_nxt[`MEMB_PIN_UB]  = 1'b0;
                     ct_nxt[`MEMB_PIN_LB]  = 1'b0;
                     ct_nxt[`MEMB_PIN_WRH] =
                        (state_r != memb_pkg::S_DATA);
                  end
               end
               else if (wm_r[0])
               begin
                  ad_nxt    = {tl_r, tl_r};
                  ad_oe_nxt = 16'h0000;
                  ct_nxt[`MEMB_PIN_UB]  = !addr_r[0];
                  ct_nxt[`MEMB_PIN_LB]  = addr_r[0];
                  ct_nxt[`MEMB_PIN_WRH] = (state_r != memb_pkg::S_DATA);
               end
               else
               begin
                  ad_nxt    = {tl_r, tl_r};
                  ad_oe_nxt = 16'h0000;
                  if (state_r == memb_pkg::S_DATA)
                  begin
                     ct_nxt[`MEMB_PIN_WRH] = !addr_r[0];
                     ct_nxt[`MEMB_PIN_WRL] = addr_r[0];
                  end
               end
            end
            default:
               ad_oe_nxt = 16'hFFFF;
         endcase
      end
   end

   // every pin leaves from a flop; reset leaves all pins floating
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ad_r    <= 16'h0000;
         ad_oe_r <= 16'hFFFF;
         up_r    <= 4'h0;
         up_oe_r <= 4'hF;
         ct_r    <= 8'h00;
         ct_oe_r <= 8'hFF;
      end
      else
      begin
         ad_r    <= ad_nxt;
         ad_oe_r <= ad_oe_nxt;
         up_r    <= up_nxt;
         up_oe_r <= up_oe_nxt;
         ct_r    <= ct_nxt;
         ct_oe_r <= ct_oe_nxt;
      end
   end

   assign ad_out          = ad_r;
   assign ad_oe_n         = ad_oe_r;
   assign upper_addr_out  = up_r;
   assign upper_addr_oe_n = up_oe_r;
   assign bus_ctrl_out    = ct_r;
   assign bus_ctrl_oe_n   = ct_oe_r;
   assign wb_ack_o        = wb_ack_r;
   assign wb_dat_o        = wb_dat_r;
   assign core_done       = done_r;
   assign core_rdata      = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // checks; helper counter measures the data phase
   logic [7:0] dcnt_r;
   logic [1:0] wcode_r;   // wait code seen when the cycle was taken
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || state_r != memb_pkg::S_DATA)
         dcnt_r <= 8'h00;
      else
         dcnt_r <= dcnt_r + 8'h01;
   end

   // kept apart from dlen_r so the check does not reuse its sum
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         wcode_r <= 2'h0;
      else if (take)
         wcode_r <= ctrl_r[`MEMB_WAIT_HI:`MEMB_WAIT_LO];
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_ports_when_off: assert property ((pm_mode != memb_pkg::PM_MP)
      && external_bus_disable_app_r && !busy && !core_req |=>
      ad_out == $past({high_bus_port_dout, low_bus_port_dout}))
      else $error("pins not handed to ports");
   a_mp_bus_only: assert property ((pm_mode == memb_pkg::PM_MP)
      |=> bus_ctrl_oe_n == 8'h00)
      else $error("bus not driving in external mode");
   a_mc_ignore_wr: assert property ((pm_mode == memb_pkg::PM_MC)
      && wb_hit && wb_we_i |=> $stable(ctrl_r))
      else $error("control written in internal mode");
   a_defer_disable: assert property (core_exec_ext && !external_bus_disable_app_r
      |=> !external_bus_disable_app_r)
      else $error("disable applied while external");
   a_idle_levels: assert property (owned && !busy
      |=> bus_ctrl_out == `MEMB_CTRL_IDLE && ad_oe_n == 16'hFFFF)
      else $error("idle pin state wrong");
   a_wait_length: assert property (state_r == memb_pkg::S_DATA && ph_done
      |-> dcnt_r == ((kind_r == memb_pkg::K_FETCH) ? 8'h03 :
          8'h0F - {4'h0, wcode_r, 2'h0}))
      else $error("data phase length wrong");
   a_ale_address: assert property (state_r == memb_pkg::S_ADDR && owned
      |=> bus_ctrl_out[`MEMB_PIN_ALE] && ad_out == $past(addr_r[16:1]))
      else $error("address not out with ale");
   a_word_even: assert property (state_r == memb_pkg::S_DATA && is_wr
      && wm_r[1] && !addr_r[0] && owned |=>
      bus_ctrl_out[`MEMB_PIN_WRH] && ad_oe_n == 16'hFFFF)
      else $error("even word write strobed");
   a_byte_one: assert property (state_r == memb_pkg::S_DATA && is_wr
      && wm_r == 2'h0 && owned |=>
      bus_ctrl_out[`MEMB_PIN_WRH] != bus_ctrl_out[`MEMB_PIN_WRL])
      else $error("byte write strobes not exclusive");
   a_ce_asleep: assert property (core_sleep && !busy && owned
      ##1 core_sleep && !busy |=> bus_ctrl_out[`MEMB_PIN_CE])
      else $error("chip select low asleep");

   c_table_read: cover property (state_r == memb_pkg::S_DATA &&
      kind_r == memb_pkg::K_TBLRD && ph_done);
   c_word_odd: cover property (state_r == memb_pkg::S_DATA && is_wr &&
      wm_r[1] && addr_r[0]);
   c_byte_sel: cover property (state_r == memb_pkg::S_DATA && is_wr &&
      wm_r == 2'h1);
   c_deferred: cover property (ctrl_r[`MEMB_EXTERNAL_BUS_DISABLE_BIT] && core_exec_ext
      ##1 !core_exec_ext ##1 external_bus_disable_app_r);
endmodule // memb_ctrl

//--- memb_defs.svh
`ifndef MEMB_DEFS_SVH
`define MEMB_DEFS_SVH
// register byte offsets on the wishbone slave
`define MEMB_ADR_CTRL      8'h00
`define MEMB_ADR_STAT      8'h04
// control register reset value and writable bits
`define MEMB_CTRL_RST      8'h00
`define MEMB_CTRL_WMASK    8'hB3
// control register field positions
`define MEMB_EXTERNAL_BUS_DISABLE_BIT     7
`define MEMB_WAIT_HI       5
`define MEMB_WAIT_LO       4
`define MEMB_WM_HI         1
`define MEMB_WM_LO         0
// status register field positions
`define MEMB_ST_OWNED      0
`define MEMB_ST_BUSY       1
`define MEMB_ST_EXTERNAL_BUS_DISABLE      2
// bus control port pin positions
`define MEMB_PIN_ALE       0
`define MEMB_PIN_OE        1
`define MEMB_PIN_WRL       2
`define MEMB_PIN_WRH       3
`define MEMB_PIN_BA0       4
`define MEMB_PIN_CE        5
`define MEMB_PIN_LB        6
`define MEMB_PIN_UB        7
// control pins while the bus owns the pins but is idle
`define MEMB_CTRL_IDLE     8'hEE
// timing counts in sys_clk cycles
`define MEMB_TCY_CLKS      8'h04
`define MEMB_ADDR_CLKS     8'h02
`define MEMB_LATCH_CLKS    8'h01
`define MEMB_FINISH_CLKS   8'h01
`define MEMB_WAIT_MAX      2'h3
`endif

//--- memb_mem_model.sv
`timescale 1ns/100ps
module memb_mem_model (
   input  wire logic        sys_clk,
   input  wire logic [15:0] ad_out,
   input  wire logic [15:0] ad_oe_n,
   input  wire logic [7:0]  bus_ctrl_out,
   input  wire logic [7:0]  bus_ctrl_oe_n,
   output logic      [15:0] ad_in,
   output logic      [7:0]  bus_ctrl_in,
   output logic      [15:0] lat,
   output logic      [7:0]  seen,
   output logic      [15:0] wdat
);
   logic [15:0] last = 16'h0000; // last word the memory drove
   logic [15:0] drv;             // memory side of the ad lines
   // released control lines float high on pull-ups
   assign bus_ctrl_in = bus_ctrl_out | bus_ctrl_oe_n;
   // released, show the inverse of the last word so stale data fails
   assign drv = !bus_ctrl_in[1] ? lat ^ 16'h5A3C : ~last;
   assign ad_in = (ad_out & ~ad_oe_n) | (drv & ad_oe_n);
   ////////////////////////////////////////////////////////////////////
   // latch address on ale, then gather every strobe seen low
   always_ff @(posedge sys_clk)
   begin
      if (!bus_ctrl_in[1])
         last <= drv;
      if (bus_ctrl_in[0])
         lat <= ad_in;
      // byte picked by ba0 or by ub/lb, both recorded
      seen <= bus_ctrl_in[0] ? 8'h00 : seen | ~bus_ctrl_in;
      if (!bus_ctrl_in[2] || !bus_ctrl_in[3])
         wdat <= ad_in;
   end
endmodule // memb_mem_model

//--- memb_phase_timer.sv
`timescale 1ns/100ps
module memb_phase_timer (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       load,
   input  wire logic [7:0] load_val,
   output logic            expired
);
   logic [7:0] cnt_r;   // cycles left in the phase

   // a phase lasts load_val+1 cycles from the load
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         cnt_r <= 8'h00;
      else if (load)
         cnt_r <= load_val;
      else if (cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end

   assign expired = (cnt_r == 8'h00);
endmodule // memb_phase_timer

//--- memb_pkg.sv
package memb_pkg;
   // program memory modes
   typedef enum logic [1:0] {PM_MP, PM_MPBB, PM_EMC, PM_MC} memb_pm_e;
   // kinds of core request
   typedef enum logic [1:0] {K_FETCH, K_TBLRD, K_TABLE_WRITE_OP} memb_kind_e;
   // bus cycle states
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_LATCH, S_DATA,
                             S_FINISH} memb_state_e;
endpackage

//--- memb_sync.sv
`timescale 1ns/100ps
module memb_sync #(
   parameter int W = 28
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_r;   // first stage, read only by the second

   // two-stage synchroniser for pin inputs
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         meta_r   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // memb_sync

//--- tb_multiplexed_ext_memory_bus.sv
`timescale 1ns/100ps
module tb_multiplexed_ext_memory_bus;
   logic sys_clk = '0, sys_rst = '1, wb_cyc_i = '0, wb_stb_i = '0;
   logic wb_we_i = '0, core_exec_ext = '0, core_sleep = '0, core_req = '0;
   logic [7:0]  wb_adr_i = '0, core_table_latch = '0, pd = 8'h5C;
   logic [7:0]  poe = 8'h0F, l = '0, pl;
   logic [3:0]  wb_sel_i = 4'hF, sw;
   logic [31:0] wb_dat_i = '0, rd;
   logic [20:0] core_addr = '0;
   memb_pkg::memb_pm_e   pm_mode = memb_pkg::PM_MP;
   memb_pkg::memb_kind_e core_kind = memb_pkg::K_FETCH;
   wire logic [31:0] wb_dat_o;
   wire logic        wb_ack_o, core_done;
   wire logic [15:0] core_rdata, ad_in, ad_out, ad_oe_n, lat, wdat;
   wire logic [7:0]  bus_ctrl_in, bus_ctrl_out, bus_ctrl_oe_n, seen;
   wire logic [3:0]  upper_addr_in, upper_addr_out, upper_addr_oe_n;
   int errors = 0, checks_done = 0, n, nf;
   assign upper_addr_in = upper_addr_out | upper_addr_oe_n;
   memb_ctrl u_memb_ctrl (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .pm_mode, .core_exec_ext, .core_sleep, .core_req, .core_kind,
      .core_addr, .core_table_latch, .core_done, .core_rdata,
      .low_bus_port_dout(pd), .low_bus_port_oe_n(poe),
      .high_bus_port_dout(pd), .high_bus_port_oe_n(poe),
      .upper_address_port_dout(pd[3:0]),
      .upper_address_port_oe_n(poe[3:0]),
      .bus_control_port_dout(pd), .bus_control_port_oe_n(poe),
      .low_bus_port_din(), .high_bus_port_din(),
      .upper_address_port_din(), .bus_control_port_din(), .ad_in,
      .ad_out, .ad_oe_n, .upper_addr_in, .upper_addr_out,
      .upper_addr_oe_n, .bus_ctrl_in, .bus_ctrl_out, .bus_ctrl_oe_n);
   memb_mem_model u_memb_mem_model (.sys_clk, .ad_out, .ad_oe_n,
      .bus_ctrl_out, .bus_ctrl_oe_n, .ad_in, .bus_ctrl_in, .lat, .seen,
      .wdat);
   always #25 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////
   task chk(input string s, input logic [31:0] e, v);
      checks_done++;
      if (e !== v)
      begin
         $display("ERROR %s expected %h seen %h", s, e, v);
         errors++;
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // bounded wait for ack or done; running out ends the run
   task hold(input logic k);
      n = 0;
      do begin @(posedge sys_clk); n++; end
      while ((k ? core_done : wb_ack_o) !== 1'h1 && n < 60);
      if (n >= 60)
      begin
         errors++;
         report_and_stop;
      end
   endtask
   // classic single access; read data taken at the ack edge
   task wb(input logic w, input logic [7:0] a, d);
      wb_cyc_i <= 1'h1; wb_stb_i <= 1'h1; wb_we_i <= w;
      wb_adr_i <= a; wb_dat_i <= {24'h0, d};
      hold(1'h0);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0; wb_stb_i <= 1'h0;
      @(posedge sys_clk);
   endtask
   // core request held until done, dropped in the following cycle
   task core(input memb_pkg::memb_kind_e k, input logic [20:0] a);
      core_req <= 1'h1; core_kind <= k; core_addr <= a;
      core_table_latch <= l;
      hold(1'h1);
      core_req <= 1'h0;
      @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'h0;
      repeat (3) @(posedge sys_clk);
      chk("idle ctrl", 8'hEE, bus_ctrl_out);
      chk("ad float", 16'hFFFF, ad_oe_n);
      wb(1'h1, 8'h00, 8'hFF);
      wb(1'h0, 8'h00, 8'h00);
      chk("ctrl reg", 8'hB3, rd);
      chk("bus kept", 8'h00, bus_ctrl_oe_n);
      wb(1'h0, 8'h08, 8'h00);
      chk("unmapped", 8'h00, rd);
      core(memb_pkg::K_FETCH, 21'h0ABCD4);
      nf = n;
      chk("fetch", core_addr[16:1] ^ 16'h5A3C, core_rdata);
      chk("addr phase", core_addr[16:1], lat);
      // each wait code must add four clocks per step
      for (int w = 0; w < 4; w++)
      begin
         wb(1'h1, 8'h00, 8'(w * 16));
         core(memb_pkg::K_TBLRD, 21'h000102);
         chk("table wait", nf + 4 * (3 - w), n);
         core(memb_pkg::K_FETCH, 21'h000102);
         chk("fetch wait", nf, n);
      end
      // every write style, even byte first so words pair up
      for (int s = 0; s < 3; s++)
         for (int b = 0; b < 2; b++)
         begin
            wb(1'h1, 8'h00, 8'(8'h30 + s));
            pl = l;
            l = 8'(8'h41 + s * 2 + b);
            core(memb_pkg::K_TABLE_WRITE_OP, {20'h00123, b[0]});
            sw = {seen[7:6], seen[3:2]};
            if (s == 0)
               chk("byte wr", b ? 2'h2 : 2'h1, sw[1:0]);
            if (s == 1)
               chk("select wr", b ? 4'hA : 4'h6, sw);
            if (s == 2)
               chk("word wr", b ? 4'hE : 4'h0,
                   b ? sw : sw & 4'h3);
            if (s < 2 || b)
               chk("wr data", s == 2 ? {l, pl} : {l, l}, wdat);
         end
      // asleep with the bus owned: chip select must stay high
      core_sleep <= 1'h1;
      repeat (3) @(posedge sys_clk);
      chk("ce asleep", 1'h1, bus_ctrl_out[5]);
      core_sleep <= 1'h0;
      pm_mode <= memb_pkg::PM_MPBB;
      core_exec_ext <= 1'h1;
      wb(1'h1, 8'h00, 8'hB3);
      chk("deferred", 8'h00, bus_ctrl_oe_n);
      core_exec_ext <= 1'h0;
      repeat (4) @(posedge sys_clk);
      chk("port ctrl", poe, bus_ctrl_oe_n);
      chk("port ad", {poe, poe}, ad_oe_n);
      core(memb_pkg::K_FETCH, 21'h1F0246);
      chk("ext fetch", core_addr[16:1] ^ 16'h5A3C, core_rdata);
      pm_mode <= memb_pkg::PM_MC;
      wb(1'h1, 8'h00, 8'h00);
      wb(1'h0, 8'h00, 8'h00);
      chk("locked reg", 8'hB3, rd);
      chk("ports only", poe, bus_ctrl_oe_n);
      report_and_stop;
   end
endmodule // tb_multiplexed_ext_memory_bus
